// File: pmc_defs.vh
// What this block does
// R1: power capability header low byte reads constant 0x01, writes ignored.
// R2: power header next pointer reads fixed 0x60, linking to message interrupt header.
// R3: power capabilities version field bits 2:0 reads constant 010b.
// R4: capabilities bit 3 and bit 5 read zero.
// R5: aux current field bits 8:6 reads constant 001b.
// R6: capabilities bits 9 and 10 read zero, no D1 or D2.
// R7: capabilities bits 15:11 read constant 11001b, wake from D0 and D3.
// R8: power state bits 1:0 reset 00b, read back, written to request state.
// R9: wake output driven only while control/status bit 8 is set.
// R10: wake status bit 15 sets on every wake event, regardless of enable.
// R11: writing one clears wake status, writing zero leaves it.
// R12: wake enable and status live in resume well, cleared by power-on reset only.
// R13: message interrupt header low byte reads constant 0x05.
// R14: message interrupt header next pointer reads zero, ending the list.
// R15: message control bit 0, reset zero, enables message interrupts.
// R16: message control bits 3:1 and 6:4 read zero, single vector.
// R17: message control bit 7 reads one, 64-bit address capable.
// R18: lower address bits 31:2 writable, bits 1:0 read zero.
// R19: upper address at 68h fully writable, reset zero.
// R20: message data at 6Ch, 16 bits writable, reset zero.
// R21: with messages enabled, interrupt becomes memory write, legacy pin stays low.
// R22: power state 00 is D0, 11 is D3hot; D1/D2 writes ignored.
//
// Purpose: constants of the power and message interrupt capability registers
// Assumes: dword-wide configuration access with byte enables
// Notes: offsets are byte addresses in configuration space
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

`define PMC_OFS_PWR_HDR 8'h50
`define PMC_OFS_PWR_CAP 8'h52
`define PMC_OFS_PWR_CTL 8'h54
`define PMC_OFS_MSG_HDR 8'h60
`define PMC_OFS_MSG_CTL 8'h62
`define PMC_OFS_MSG_ALO 8'h64
`define PMC_OFS_MSG_AHI 8'h68
`define PMC_OFS_MSG_DAT 8'h6c

`define PMC_PWR_CAP_ID 8'h01
`define PMC_PWR_NEXT 8'h60
`define PMC_PWR_VERSION 3'h2
`define PMC_PWR_AUX_CUR 3'h1
`define PMC_PWR_WAKE_SUP 5'h19
`define PMC_MSG_CAP_ID 8'h05
`define PMC_MSG_NEXT 8'h00

`define PMC_PSTATE_D0 2'h0
`define PMC_PSTATE_D3 2'h3
`define PMC_BIT_WAKE_EN 8
`define PMC_BIT_WAKE_STS 15
`define PMC_BIT_MSG_EN 0
`define PMC_BIT_MSG_64 7

`define PMC_RST_PSTATE 2'h0
`define PMC_RST_ADDR 32'h00000000
`define PMC_RST_DATA 16'h0000

`endif

// File: pmc_regs.v
// Purpose: power management and message interrupt capability register bank
// Assumes: one access per request, answered with cfg_ack two cycles after cfg_req
// Notes: wake enable/status and wake_oe run on por_rst, everything else on sys_rst
// Notes: constant fields are wired into the read mux and never stored
// Notes: one posted message per rising interrupt edge, at most one waits
`include "pmc_defs.vh"

module pmc_regs #(
    parameter ADDR_W = 8
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire por_rst,
    input wire cfg_req,
    input wire cfg_we,
    input wire [ADDR_W-1:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_ack,
    input wire wake_event,
    output reg wake_oe,
    input wire irq_level,
    output reg intx_out,
    output reg msg_wr_valid,
    input wire msg_wr_ready,
    output reg [63:0] msg_wr_addr,
    output reg [15:0] msg_wr_data,
    output reg [1:0] power_state
);

    // byte-lane merge, used by every writable dword
    function [31:0] pmc_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        integer i;
        begin
            pmc_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    pmc_merge[8*i +: 8] = new_val[8*i +: 8];
                end
            end
        end
    endfunction

    reg req_q_reg;
    reg we_q_reg;
    reg [ADDR_W-1:0] addr_q_reg;
    reg [3:0] be_q_reg;
    reg [31:0] wdata_q_reg;
    reg wake_en_reg;
    reg wake_sts_reg;
    reg msg_en_reg;
    reg [29:0] addr_lo_reg;
    reg [31:0] addr_hi_reg;
    reg [15:0] data_reg;
    reg irq_q_reg;
    reg msg_pend_reg;
    reg [31:0] rd_next;
    reg [31:0] wr_merged;
    reg [1:0] ps_req;
    wire [ADDR_W-1:0] dw_addr;
    wire wr_stb;
    wire irq_rise;
    // power control dword strobes, shared by both reset domains
    wire hit_pwr_ctl;
    wire wr_ctl_lo;
    wire wr_ctl_hi;
    // resume-well clear request
    wire wake_clr;
    // power state request check
    wire ps_legal;
    // message delivery helpers
    wire msg_queue;
    wire msg_start;
    wire [63:0] msg_addr_now;

    // only the dword address counts; byte lanes pick the half
    assign dw_addr = {addr_q_reg[ADDR_W-1:2], 2'b00};
    assign wr_stb = req_q_reg & we_q_reg;
    assign irq_rise = irq_level & ~irq_q_reg;

    // the power control dword feeds flops of two reset domains
    assign hit_pwr_ctl = (dw_addr == `PMC_OFS_PWR_CTL);
    assign wr_ctl_lo = wr_stb & hit_pwr_ctl & be_q_reg[0];
    assign wr_ctl_hi = wr_stb & hit_pwr_ctl & be_q_reg[1];
    // write one to clear; a zero in bit 15 leaves the status alone
    assign wake_clr = wr_ctl_hi & wdata_q_reg[`PMC_BIT_WAKE_STS]; // [R11]
    // d1 and d2 are not built, so only d0 and d3hot are taken
    assign ps_legal = (ps_req == `PMC_PSTATE_D0) | (ps_req == `PMC_PSTATE_D3); // [R22]

    // an edge meeting a message in flight, even one accepted this cycle,
    // is parked so that it goes out next instead of being lost
    assign msg_queue = msg_wr_valid & irq_rise & msg_en_reg;
    assign msg_start = ~msg_wr_valid & msg_en_reg & (irq_rise | msg_pend_reg); // [R21]
    // message target keeps the low address bits at zero
    assign msg_addr_now = {addr_hi_reg, addr_lo_reg, 2'b00}; // [R18]

    // access timing, seen from the bus:
    //   cycle 0: request, direction, address, lanes and data presented
    //   cycle 1: request held in flops; decode and byte merge settle
    //   cycle 2: acknowledge pulse; read data registered, writes landed
    // a request every cycle is fine, the pipeline never stalls
    // trade-off: one cycle of latency buys a decode path fed only by flops
    // capture the request so decode works from flops
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_q_reg <= 1'b0;
            we_q_reg <= 1'b0;
            addr_q_reg <= {ADDR_W{1'b0}};
            be_q_reg <= 4'h0;
            wdata_q_reg <= 32'h00000000;
        end else begin
            req_q_reg <= cfg_req;
            if (cfg_req) begin
                we_q_reg <= cfg_we;
                addr_q_reg <= cfg_addr;
                be_q_reg <= cfg_be;
                wdata_q_reg <= cfg_wdata;
            end
        end
    end

    // dwords served here:
    //   50h  [15:0] power header, [31:16] power capabilities, all wired
    //   54h  [1:0] power state, [8] wake enable, [15] wake status
    //   60h  [15:0] message header, [31:16] message control
    //   64h  [31:2] lower message address, [1:0] zero
    //   68h  upper message address
    //   6ch  [15:0] message data, [31:16] zero
    // every other dword reads zero and drops writes
    // read mux; constants are wired, never stored
    always @* begin
        rd_next = 32'h00000000;
        wr_merged = 32'h00000000;
        ps_req = 2'h0;
        case (dw_addr)
            `PMC_OFS_PWR_HDR: begin
                rd_next[7:0] = `PMC_PWR_CAP_ID; // [R1]
                rd_next[15:8] = `PMC_PWR_NEXT; // [R2]
                rd_next[18:16] = `PMC_PWR_VERSION; // [R3]
                rd_next[19] = 1'b0; // [R4]
                rd_next[21] = 1'b0; // [R4]
                rd_next[24:22] = `PMC_PWR_AUX_CUR; // [R5]
                rd_next[26:25] = 2'b00; // [R6]
                rd_next[31:27] = `PMC_PWR_WAKE_SUP; // [R7]
            end
            `PMC_OFS_PWR_CTL: begin
                rd_next[1:0] = power_state; // [R8]
                rd_next[`PMC_BIT_WAKE_EN] = wake_en_reg;
                rd_next[`PMC_BIT_WAKE_STS] = wake_sts_reg;
            end
            `PMC_OFS_MSG_HDR: begin
                rd_next[7:0] = `PMC_MSG_CAP_ID; // [R13]
                rd_next[15:8] = `PMC_MSG_NEXT; // [R14]
                rd_next[16 + `PMC_BIT_MSG_EN] = msg_en_reg;
                rd_next[22:17] = 6'h00; // [R16]
                rd_next[16 + `PMC_BIT_MSG_64] = 1'b1; // [R17]
            end
            `PMC_OFS_MSG_ALO: begin
                rd_next = {addr_lo_reg, 2'b00}; // [R18]
            end
            `PMC_OFS_MSG_AHI: begin
                rd_next = addr_hi_reg;
            end
            `PMC_OFS_MSG_DAT: begin
                rd_next = {16'h0000, data_reg};
            end
            default: begin
                rd_next = 32'h00000000; // unmapped reads zero
            end
        endcase
        wr_merged = pmc_merge(rd_next, wdata_q_reg, be_q_reg);
        ps_req = wr_merged[1:0];
    end

    // answer one cycle after capture
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_ack <= req_q_reg;
            if (req_q_reg & ~we_q_reg) begin
                cfg_rdata <= rd_next;
            end
        end
    end

    // function-reset registers
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_state <= `PMC_RST_PSTATE; // [R8]
            msg_en_reg <= 1'b0; // [R15]
            addr_lo_reg <= 30'h00000000;
            addr_hi_reg <= `PMC_RST_ADDR; // [R19]
            data_reg <= `PMC_RST_DATA; // [R20]
        end else if (wr_stb) begin
            case (dw_addr)
                `PMC_OFS_PWR_CTL: begin
                    // d1/d2 unsupported, so such writes keep the old state
                    if (wr_ctl_lo && ps_legal) begin
                        power_state <= ps_req; // [R8] [R22]
                    end
                end
                `PMC_OFS_MSG_HDR: begin
                    msg_en_reg <= wr_merged[16 + `PMC_BIT_MSG_EN]; // [R15]
                end
                `PMC_OFS_MSG_ALO: begin
                    addr_lo_reg <= wr_merged[31:2]; // [R18]
                end
                `PMC_OFS_MSG_AHI: begin
                    addr_hi_reg <= wr_merged; // [R19]
                end
                `PMC_OFS_MSG_DAT: begin
                    data_reg <= wr_merged[15:0]; // [R20]
                end
                default: begin
                    data_reg <= data_reg;
                end
            endcase
        end
    end

    // resume-well bits: survive sys_rst, only por_rst clears them
    always @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            wake_en_reg <= 1'b0; // [R12]
            wake_sts_reg <= 1'b0; // [R12]
        end else begin
            if (wr_ctl_hi) begin
                wake_en_reg <= wdata_q_reg[`PMC_BIT_WAKE_EN]; // [R9]
            end
            // a new event wins over a same-cycle clear
            if (wake_event) begin
                wake_sts_reg <= 1'b1; // [R10]
            end else if (wake_clr) begin
                wake_sts_reg <= 1'b0; // [R11]
            end
        end
    end

    // wake pin pulls low only when enabled; on the resume well too
    always @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            wake_oe <= 1'b0;
        end else begin
            wake_oe <= wake_event & wake_en_reg; // [R9]
        end
    end

    // interrupt delivery: legacy level or one posted message per rising edge
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q_reg <= 1'b0;
            intx_out <= 1'b0;
            msg_pend_reg <= 1'b0;
            msg_wr_valid <= 1'b0;
            msg_wr_addr <= 64'h0000000000000000;
            msg_wr_data <= 16'h0000;
        end else begin
            irq_q_reg <= irq_level;
            intx_out <= irq_level & ~msg_en_reg; // [R21]
            // an edge during a busy message is remembered, not dropped
            // limitation: further edges while one already waits are merged
            if (msg_queue) begin
                msg_pend_reg <= 1'b1;
            end else if (~msg_wr_valid & msg_pend_reg) begin
                msg_pend_reg <= 1'b0;
            end
            if (msg_wr_valid) begin
                if (msg_wr_ready) begin
                    msg_wr_valid <= 1'b0;
                end
            end else if (msg_start) begin
                msg_wr_valid <= 1'b1; // [R21]
                msg_wr_addr <= msg_addr_now;
                msg_wr_data <= data_reg;
            end
        end
    end

endmodule

// File: pmc_props.sv
// Purpose: port checks of the capability bank
// Assumes: answer two edges after a taken request
// Notes: idle during either reset
`include "pmc_defs.vh"
module pmc_props #(
    parameter ADDR_W = 8
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire por_rst,
    input wire cfg_req,
    input wire cfg_we,
    input wire [ADDR_W-1:0] cfg_addr,
    input wire [31:0] cfg_rdata,
    input wire cfg_ack,
    input wire wake_event,
    input wire wake_oe,
    input wire irq_level,
    input wire intx_out,
    input wire msg_wr_valid,
    input wire msg_wr_ready,
    input wire [63:0] msg_wr_addr,
    input wire [15:0] msg_wr_data,
    input wire [1:0] power_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst || por_rst);
    // read requests per dword
    wire rd = cfg_req && !cfg_we;
    wire [5:0] dw = cfg_addr[7:2];
    AST_PWR_HDR: assert property (
        rd && dw == 6'h14 |-> ##2 cfg_ack && cfg_rdata[15:0] == 16'h6001)
        else $error("power header read wrong");
    AST_PWR_CAP: assert property (
        rd && dw == 6'h14 |-> ##2 cfg_rdata[31:16] == 16'hc842)
        else $error("power capabilities read wrong");
    // bit 16 is the writable enable, so it is left out here
    AST_MSG_HDR: assert property (
        rd && dw == 6'h18 |-> ##2 {cfg_rdata[31:17], cfg_rdata[15:0]} == 31'h00400005)
        else $error("message header read wrong");
    AST_ALO_ALIGN: assert property (rd && dw == 6'h19 |-> ##2 cfg_rdata[1:0] == 2'b00)
        else $error("lower address low bits not zero");
    AST_WAKE_GATE: assert property (wake_oe |-> $past(wake_event))
        else $error("wake driven without a wake event");
    AST_MSG_HOLD: assert property (msg_wr_valid && !msg_wr_ready |=> msg_wr_valid
        && $stable(msg_wr_addr) && $stable(msg_wr_data))
        else $error("message write dropped or changed while stalled");
    AST_INTX_SRC: assert property (intx_out |-> $past(irq_level))
        else $error("legacy pin without a source");
    AST_PSTATE_ACK: assert property ($changed(power_state) |-> cfg_ack)
        else $error("power state moved without an access");
    AST_PSTATE_LEGAL: assert property (power_state == 2'b00 || power_state == 2'b11)
        else $error("unsupported power state");
    AST_MSG_ALIGN: assert property (msg_wr_valid |-> msg_wr_addr[1:0] == 2'b00)
        else $error("message address not dword aligned");
    COV_MSG: cover property (msg_wr_valid && msg_wr_ready);
    COV_WAKE: cover property (wake_oe);
    COV_STALL: cover property (msg_wr_valid && !msg_wr_ready);
endmodule
bind pmc_regs pmc_props #(.ADDR_W(ADDR_W)) u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .por_rst(por_rst), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wake_event(wake_event), .wake_oe(wake_oe),
    .irq_level(irq_level), .intx_out(intx_out), .msg_wr_valid(msg_wr_valid),
    .msg_wr_ready(msg_wr_ready), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data),
    .power_state(power_state));

// File: pmc_msg_sink.sv
// Purpose: memory sink that takes message writes
// Assumes: accepts on valid and ready at an edge
// Notes: stalls at random so held writes are exercised
module pmc_msg_sink (
    input wire ref_clk,
    output logic msg_wr_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 32'hb951;
    // ready on a coin toss each cycle
    always @(posedge ref_clk) msg_wr_ready <= $random(seed);
endmodule

// File: pm_msi_capability_regs_bench.sv
// Purpose: self-checking bench of the capability bank
// Assumes: answer two edges after a taken request
// Notes: the model keeps every writable register in bench variables
module pm_msi_capability_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, sys_rst = 1, por_rst = 1, cfg_req = 0, cfg_we = 0, wake_event = 0;
    logic irq_level = 0, msg_wr_ready, cfg_ack, wake_oe, intx_out, msg_wr_valid;
    logic [7:0] cfg_addr = 0;
    logic [3:0] cfg_be = 0;
    logic [31:0] cfg_wdata = 0, cfg_rdata, m_alo = 0, m_ahi = 0;
    logic [63:0] msg_wr_addr;
    logic [15:0] msg_wr_data, m_dat = 0;
    logic [1:0] power_state, m_ps = 0;
    logic m_wen = 0, m_wsts = 0, m_men = 0;
    logic [79:0] exp_q[$];
    integer n_mismatch = 0, checked = 0, seed = 32'hb951, i;
    pmc_regs uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wake_event(wake_event), .wake_oe(wake_oe),
        .irq_level(irq_level), .intx_out(intx_out), .msg_wr_valid(msg_wr_valid),
        .msg_wr_ready(msg_wr_ready), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data),
        .power_state(power_state));
    pmc_msg_sink u_sink (.ref_clk(ref_clk), .msg_wr_ready(msg_wr_ready));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] model(input logic [7:0] a);
        case (a[7:2])
            6'h14: model = 32'hc8426001;
            6'h15: model = {16'h0, m_wsts, 6'h0, m_wen, 6'h0, m_ps};
            6'h18: model = {8'h0, 7'h40, m_men, 16'h0005};
            6'h19: model = {m_alo[31:2], 2'b00};
            6'h1a: model = m_ahi;
            6'h1b: model = {16'h0, m_dat};
            default: model = 32'h0;
        endcase
    endfunction
    // one access; the model follows writes, reads are compared
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        cfg_req <= 1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_req <= 0;
        // ack stands only in the cycle after this edge; read data holds until the next read
        @(posedge ref_clk);
        if (we && a == 8'h54) begin
            if (be[0] && d[1:0] != 2'h1 && d[1:0] != 2'h2) m_ps = d[1:0];
            if (be[1]) m_wen = d[8];
            if (be[1] && d[15]) m_wsts = 0;
        end
        if (we && a == 8'h60 && be[2]) m_men = d[16];
        if (we && a == 8'h64) m_alo = d;
        if (we && a == 8'h68) m_ahi = d;
        if (we && a == 8'h6c) m_dat = d[15:0];
        #1 check(cfg_ack, 1);
        if (!we) check(cfg_rdata, model(a));
        check(power_state, m_ps);
        @(posedge ref_clk);
    endtask
    task automatic wake;
        wake_event <= 1;
        @(posedge ref_clk);
        wake_event <= 0;
        m_wsts = 1;
        #1 check(wake_oe, m_wen);
        @(posedge ref_clk);
        acc(0, 8'h54, 0, 0);
    endtask
    task automatic irq(input logic en);
        integer k;
        irq_level <= 1;
        if (en) exp_q.push_back({m_ahi, m_alo[31:2], 2'b00, m_dat});
        repeat (2) @(posedge ref_clk);
        #1 check(intx_out, !en);
        @(posedge ref_clk);
        irq_level <= 0;
        for (k = 0; k < 60 && exp_q.size() > 0; k++) @(posedge ref_clk);
        check(exp_q.size(), 0);
        // let the low level be sampled before any next rise
        @(posedge ref_clk);
    endtask
    // every accepted message write against the queue
    always @(posedge ref_clk) if (msg_wr_valid && msg_wr_ready) begin
        check({msg_wr_addr, msg_wr_data}, exp_q.pop_front());
    end
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000 n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 0;
        por_rst <= 0;
        @(posedge ref_clk);
        for (i = 8'h50; i < 8'h74; i += 4) acc(0, i, 0, 32'hffffffff);
        for (i = 0; i < 9; i++) begin
            acc(1, 8'h64 + 4 * (i % 3), 4'hf, $random(seed));
            acc(0, 8'h64 + 4 * (i % 3), 0, 0);
        end
        acc(1, 8'h50, 4'hf, 32'h0);
        acc(0, 8'h50, 0, 0);
        for (i = 0; i < 4; i++) acc(1, 8'h54, 4'h1, 3 - i);
        acc(1, 8'h54, 4'h1, 32'h3);
        irq(0);
        acc(1, 8'h60, 4'h4, 32'h10000);
        acc(0, 8'h60, 0, 0);
        irq(1);
        irq(1);
        wake();
        acc(1, 8'h54, 4'h2, 32'h0100);
        wake();
        acc(1, 8'h54, 4'h2, 32'h8100);
        acc(0, 8'h54, 0, 0);
        wake();
        sys_rst <= 1;
        @(posedge ref_clk);
        sys_rst <= 0;
        {m_ps, m_men, m_alo, m_ahi, m_dat} = 0;
        @(posedge ref_clk);
        for (i = 8'h54; i < 8'h70; i += 4) acc(0, i, 0, 0);
        por_rst <= 1;
        @(posedge ref_clk);
        por_rst <= 0;
        {m_wen, m_wsts} = 0;
        @(posedge ref_clk);
        acc(0, 8'h54, 0, 0);
        finish_test;
    end
endmodule
